// file: ccfr_checker.sv
// Purpose: port assertions for the clock failure recovery block
// Assumes: single core clock domain
// Notes:   bound to the top module below
`timescale 1ns/1ps
`include "ccfr_regs.svh"
module ccfr_checker (
   input wire logic                   core_clk_i,
   input wire logic                   reset_i,
   input wire logic                   wdt_osc_i,
   input wire logic [`CCFR_SEL_W-1:0] clock_source_select_i,
   input wire logic                   wdt_osc_enable_i,
   input wire logic                   primary_osc_fail_detect_enable_i,
   input wire logic                   wdt_osc_fail_detect_enable_i,
   input wire logic                   trap_ack_i,
   input wire logic                   sys_clk_o,
   input wire logic                   on_wdt_clk_o,
   input wire logic                   primary_fail_trap_o,
   input wire logic                   wdt_fail_trap_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // filter needs a few quiet cycles before the copy settles
   sequence s_wdt_quiet;
      (on_wdt_clk_o && $stable(wdt_osc_i))[*6];
   endsequence
   a_trap_stands: assert property (primary_fail_trap_o && !trap_ack_i |=> primary_fail_trap_o)
      else $error("primary trap dropped without ack");
   a_switch_with_trap: assert property ($rose(on_wdt_clk_o) |-> primary_fail_trap_o)
      else $error("switch without trap");
   a_switch_enabled: assert property ($rose(on_wdt_clk_o) |-> $past(wdt_osc_enable_i))
      else $error("switch while wdt osc off");
   a_off_no_switch: assert property (!wdt_osc_enable_i |=> !on_wdt_clk_o)
      else $error("on wdt clock while disabled");
   a_sel_no_switch: assert property ($rose(on_wdt_clk_o)
      |-> $past(clock_source_select_i) != `CCFR_SEL_WDT)
      else $error("switch with wdt already selected");
   a_sys_follows_wdt: assert property (s_wdt_quiet |-> sys_clk_o == wdt_osc_i)
      else $error("system clock not on wdt osc");
   a_sel_change_drop: assert property (on_wdt_clk_o && $changed(clock_source_select_i)
      |=> !on_wdt_clk_o)
      else $error("switch kept after select change");
   a_prim_det_on: assert property ($rose(primary_fail_trap_o)
      |-> $past(primary_osc_fail_detect_enable_i))
      else $error("primary trap with detector off");
   a_wdt_det_on: assert property ($rose(wdt_fail_trap_o) |-> $past(wdt_osc_fail_detect_enable_i))
      else $error("wdt trap with detector off");
endmodule
bind ccfr_clock_failure_recovery ccfr_checker ccfr_checker_inst (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .wdt_osc_i(wdt_osc_i),
   .clock_source_select_i(clock_source_select_i), .wdt_osc_enable_i(wdt_osc_enable_i),
   .primary_osc_fail_detect_enable_i(primary_osc_fail_detect_enable_i),
   .wdt_osc_fail_detect_enable_i(wdt_osc_fail_detect_enable_i), .trap_ack_i(trap_ack_i),
   .sys_clk_o(sys_clk_o), .on_wdt_clk_o(on_wdt_clk_o),
   .primary_fail_trap_o(primary_fail_trap_o), .wdt_fail_trap_o(wdt_fail_trap_o));

// file: ccfr_clock_failure_recovery.sv
// Purpose: detect primary oscillator failure, trap the cpu, fall back to the wdt oscillator
// Assumes: both oscillators far slower than core_clk_i; both arrive as pins
// Notes:   sys_clk_o is a sampled copy of the chosen oscillator
//
// How it works
// - primary failure raises a trap toward the cpu that cannot be masked.
// - on primary failure the system clock moves to the wdt oscillator unaided.
// - the move happens only while the wdt oscillator is enabled.
// - no move when the wdt oscillator already is the chosen source.
// - the move ignores the wdt reset function; only the oscillator matters.
// - the cpu keeps running on the slow clock and takes the failure vector.
// - failure flagged below about 1 kHz, give or take a tenth.
// - any clock slower than the threshold counts as failed, even if running.
`timescale 1ns/1ps
`include "ccfr_regs.svh"

module ccfr_clock_failure_recovery #(
   parameter int unsigned WDT_EDGES_WIN   = `CCFR_WDT_EDGES_WIN,
   parameter int unsigned WDT_TIMEOUT_CYC = `CCFR_WDT_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic                    core_clk_i,
   input  wire logic                    reset_i,
   // oscillator pins
   input  wire logic                    primary_osc_i,
   input  wire logic                    wdt_osc_i,
   // configuration
   input  wire logic [`CCFR_SEL_W-1:0]  clock_source_select_i,
   input  wire logic                    wdt_osc_enable_i,
   input  wire logic                    primary_osc_fail_detect_enable_i,
   input  wire logic                    wdt_osc_fail_detect_enable_i,
   // cpu side
   input  wire logic                    trap_ack_i,
   output logic                         sys_clk_o,
   output logic                         on_wdt_clk_o,
   output logic                         primary_fail_trap_o,
   output logic                         wdt_fail_trap_o
);

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   // a filtered level moves only once stages two and three agree
   function automatic logic filt(input logic cur, input logic s2, input logic s3);
      filt = (s2 == s3) ? s3 : cur;
   endfunction

   logic [2:0] pri_sync_reg;
   logic [2:0] wdt_sync_reg;
   logic       pri_lvl_reg;
   logic       wdt_lvl_reg;
   logic       pri_lvl_next;
   logic       wdt_lvl_next;
   logic       pri_rise;
   logic       wdt_rise;

   // levels reset low; a pin already high gives one early edge, which restarts a count and, from the wdt pin, also advances the primary window
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pri_sync_reg <= 3'h0;
         wdt_sync_reg <= 3'h0;
      end else begin
         pri_sync_reg <= {pri_sync_reg[1:0], primary_osc_i};
         wdt_sync_reg <= {wdt_sync_reg[1:0], wdt_osc_i};
      end
   end

   assign pri_lvl_next = filt(pri_lvl_reg, pri_sync_reg[1], pri_sync_reg[2]);
   assign wdt_lvl_next = filt(wdt_lvl_reg, wdt_sync_reg[1], wdt_sync_reg[2]);
   assign pri_rise     = pri_lvl_next & ~pri_lvl_reg;
   assign wdt_rise     = wdt_lvl_next & ~wdt_lvl_reg;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pri_lvl_reg <= 1'b0;
         wdt_lvl_reg <= 1'b0;
      end else begin
         pri_lvl_reg <= pri_lvl_next;
         wdt_lvl_reg <= wdt_lvl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // primary detector: wdt edges since the last primary edge

   localparam int unsigned WIN_W = $clog2(WDT_EDGES_WIN + 1);
   localparam int unsigned TO_W  = $clog2(WDT_TIMEOUT_CYC + 1);

   logic [WIN_W-1:0] win_cnt_reg;
   logic             win_full;
   logic             pri_failed_reg;
   logic             pri_fail_evt;
   logic             sel_is_wdt;

   assign sel_is_wdt = (clock_source_select_i == `CCFR_SEL_WDT);
   assign win_full   = (win_cnt_reg == WIN_W'(WDT_EDGES_WIN - 1));

   // fires once per failure, re-armed by the next primary edge;
   // a primary edge in the closing cycle is still a sign of life
   assign pri_fail_evt = primary_osc_fail_detect_enable_i & ~pri_failed_reg & wdt_rise
                         & ~pri_rise & win_full;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         win_cnt_reg    <= '0;
         pri_failed_reg <= 1'b0;
      end else if (pri_rise || !primary_osc_fail_detect_enable_i) begin
         win_cnt_reg    <= '0;
         pri_failed_reg <= 1'b0;
      end else if (wdt_rise) begin
         if (!win_full)
            win_cnt_reg <= win_cnt_reg + 1'b1;
         if (pri_fail_evt)
            pri_failed_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wdt oscillator detector: core cycles since the last wdt edge

   // the primary window stalls with the wdt oscillator; this timer catches that case
   logic [TO_W-1:0] to_cnt_reg;
   logic            to_full;
   logic            wdt_failed_reg;
   logic            wdt_fail_evt;

   assign to_full      = (to_cnt_reg == TO_W'(WDT_TIMEOUT_CYC - 1));
   assign wdt_fail_evt = wdt_osc_fail_detect_enable_i & ~wdt_failed_reg & ~wdt_rise
                         & to_full;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         to_cnt_reg     <= '0;
         wdt_failed_reg <= 1'b0;
      end else if (wdt_rise || !wdt_osc_fail_detect_enable_i) begin
         to_cnt_reg     <= '0;
         wdt_failed_reg <= 1'b0;
      end else begin
         if (!to_full)
            to_cnt_reg <= to_cnt_reg + 1'b1;
         if (wdt_fail_evt)
            wdt_failed_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trap flags: no mask; a new event beats the acknowledge
   // one acknowledge clears both flags, so the handler reads both first

   always_ff @(posedge core_clk_i) begin
      if (reset_i)
         primary_fail_trap_o <= 1'b0;
      else if (pri_fail_evt)
         primary_fail_trap_o <= 1'b1;
      else if (trap_ack_i)
         primary_fail_trap_o <= 1'b0;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i)
         wdt_fail_trap_o <= 1'b0;
      else if (wdt_fail_evt)
         wdt_fail_trap_o <= 1'b1;
      else if (trap_ack_i)
         wdt_fail_trap_o <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source state

   ccfr_pkg::ccfr_state_t state_reg;
   ccfr_pkg::ccfr_state_t state_next;
   logic [`CCFR_SEL_W-1:0] sel_prev_reg;

   // wdt reset function is not an input here: only the oscillator enable gates it
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ccfr_pkg::CCFR_ST_PRIMARY: begin
            if (pri_fail_evt && wdt_osc_enable_i && !sel_is_wdt)
               state_next = ccfr_pkg::CCFR_ST_WDT;
         end
         ccfr_pkg::CCFR_ST_WDT: begin
            // software rewrote the source select: hand back
            // a disabled wdt oscillator cannot carry the cpu any longer
            if (clock_source_select_i != sel_prev_reg || !wdt_osc_enable_i)
               state_next = ccfr_pkg::CCFR_ST_PRIMARY;
         end
         default: state_next = ccfr_pkg::CCFR_ST_PRIMARY;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_reg    <= ccfr_pkg::CCFR_ST_PRIMARY;
         sel_prev_reg <= `CCFR_SEL_RESET;
      end else begin
         state_reg    <= state_next;
         sel_prev_reg <= clock_source_select_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock out: the substitute keeps the cpu running after the switch

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sys_clk_o    <= 1'b0;
         on_wdt_clk_o <= 1'b0;
      end else begin
         on_wdt_clk_o <= (state_next == ccfr_pkg::CCFR_ST_WDT);
         if (state_next == ccfr_pkg::CCFR_ST_WDT || sel_is_wdt)
            sys_clk_o <= wdt_lvl_next;
         else
            sys_clk_o <= pri_lvl_next;
      end
   end

endmodule

// file: ccfr_osc_model.sv
// Purpose: primary and wdt oscillator sources
// Assumes: a stopped oscillator freezes at its last level
// Notes:   half periods in ns
`timescale 1ns/1ps
module ccfr_osc_model #(
   parameter int PRIM_HALF      = 40,
   parameter int PRIM_SLOW_HALF = 800,
   parameter int WDT_HALF       = 200
) (
   // run controls
   input  wire logic prim_run_i,
   input  wire logic prim_slow_i,
   input  wire logic wdt_run_i,
   // oscillator pins
   output logic      prim_osc_o,
   output logic      wdt_osc_o
);
   initial begin
      prim_osc_o = 1'b0;
      wdt_osc_o  = 1'b0;
   end
   // slow mode: still running, but well below the detector's threshold
   always begin
      if (prim_slow_i) #(PRIM_SLOW_HALF);
      else #(PRIM_HALF);
      if (prim_run_i) prim_osc_o = ~prim_osc_o;
   end
   always #(WDT_HALF) if (wdt_run_i) wdt_osc_o = ~wdt_osc_o;
endmodule

// file: ccfr_pkg.sv
// Purpose: shared types of the clock failure recovery block
// Assumes: nothing
// Notes:   constants live in ccfr_regs.svh
package ccfr_pkg;
   typedef enum logic {
      CCFR_ST_PRIMARY,
      CCFR_ST_WDT
   } ccfr_state_t;
endpackage

// file: ccfr_regs.svh
// Purpose: constants for the clock failure recovery block
// Assumes: core clock at 100 MHz
// Notes:   counts derive from the rates held here
`ifndef CCFR_REGS_SVH
`define CCFR_REGS_SVH

`define CCFR_CORE_CLK_HZ      100000000
`define CCFR_FAIL_THRESH_HZ   1000
// longest wait rounds down; at least one cycle
`define CCFR_WDT_TIMEOUT_CYC  (`CCFR_CORE_CLK_HZ / `CCFR_FAIL_THRESH_HZ)
`define CCFR_WDT_OSC_HZ       10000
`define CCFR_WDT_EDGES_WIN    (`CCFR_WDT_OSC_HZ / `CCFR_FAIL_THRESH_HZ)
`define CCFR_SEL_W            3
`define CCFR_SEL_WDT          3'h4
`define CCFR_SEL_RESET        3'h0

`endif

// file: tb_top.sv
// Purpose: self-checking bench for clock failure recovery
// Assumes: short windows set through parameters
// Notes:   wdt period 40 core cycles, timeout 50
`timescale 1ns/1ps
`include "ccfr_regs.svh"
module tb_top;
   logic clk = 0, rst = 1, prun = 1, pslow = 0, wrun = 1, ack = 0, en = 1, pdet = 1, wdet = 1;
   logic [`CCFR_SEL_W-1:0] sel = '0;
   logic                   sys_clk, on_wdt, ptrap, wtrap, posc, wosc;
   int                     fail_count = 0, samples_checked = 0, cyc = 0;
   always #5 clk = ~clk;
   ccfr_osc_model ccfr_osc_model_inst (.prim_run_i(prun), .prim_slow_i(pslow),
      .wdt_run_i(wrun), .prim_osc_o(posc), .wdt_osc_o(wosc));
   ccfr_clock_failure_recovery #(.WDT_EDGES_WIN(2), .WDT_TIMEOUT_CYC(50))
      ccfr_clock_failure_recovery_inst (.core_clk_i(clk), .reset_i(rst),
      .primary_osc_i(posc), .wdt_osc_i(wosc), .clock_source_select_i(sel),
      .wdt_osc_enable_i(en), .primary_osc_fail_detect_enable_i(pdet),
      .wdt_osc_fail_detect_enable_i(wdet), .trap_ack_i(ack), .sys_clk_o(sys_clk),
      .on_wdt_clk_o(on_wdt), .primary_fail_trap_o(ptrap), .wdt_fail_trap_o(wtrap));
   task automatic chk(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   task print_verdict;
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic healthy_case;
      repeat (300) @(posedge clk);
      #1 chk("healthy", 1'b0, ptrap);
      $display("test healthy done");
   endtask
   // source set with detectors off; then stop or slow the primary, expect trap, ack, restore
   task automatic fail_case(input logic e, input logic [`CCFR_SEL_W-1:0] s, input logic sw,
                            input logic slw);
      @(posedge clk) {pdet, wdet} <= 2'b00;
      @(posedge clk) {en, sel} <= {e, s};
      @(posedge clk) {pdet, wdet} <= 2'b11;
      {prun, pslow} <= {slw, slw};
      for (int i = 0; i < 300 && ptrap !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("ptrap", 1'b1, ptrap);
      chk("on_wdt", sw, on_wdt);
      @(wosc);
      repeat (6) @(posedge clk);
      #1 chk("sys_clk", (sw || s == `CCFR_SEL_WDT) ? wosc : posc, sys_clk);
      @(posedge clk) ack <= 1'b1;
      @(posedge clk) ack <= 1'b0;
      #1 chk("ack", 1'b0, ptrap);
      @(posedge clk) {pdet, wdet} <= 2'b00;
      @(posedge clk) {sel, prun, pslow} <= {3'h1, 1'b1, 1'b0};
      repeat (2) @(posedge clk);
      #1 chk("back", 1'b0, on_wdt);
      @(posedge clk) {en, sel} <= {1'b1, 3'h0};
      repeat (10) @(posedge clk);
      {pdet, wdet} <= 2'b11;
      $display("test fail_case %b %h %b done", e, s, slw);
   endtask
   task automatic wdt_fail_case;
      @(posedge clk) wrun <= 1'b0;
      for (int i = 0; i < 150 && wtrap !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("wtrap", 1'b1, wtrap);
      $display("test wdt_fail done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      healthy_case;
      fail_case(1'b1, 3'h0, 1'b1, 1'b0);
      fail_case(1'b1, 3'h0, 1'b1, 1'b1);
      fail_case(1'b0, 3'h0, 1'b0, 1'b0);
      fail_case(1'b1, `CCFR_SEL_WDT, 1'b0, 1'b0);
      wdt_fail_case;
      print_verdict;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict;
      end
   end
endmodule
